// ---- logic/tmr_timer.v ----
// Purpose: 16-bit timer with capture, compare, overflow flags on AHB-Lite
// Assumes: byte registers at word addresses 4*offset, data in bits 7:0
// Notes: zero wait states, always OKAY; halt and wait are mode inputs
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`include "tmr_consts.vh"
`default_nettype none
module tmr_timer (
  input wire clk,
  input wire srst,
  input wire clkEn,
  input wire hsel,
  input wire [9:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire captureInputPin,
  input wire waitMode,
  input wire haltMode,
  output reg compareOutputPin,
  output reg timerIrq,
  output reg wakeReq
);
  // word index decode for address-phase accesses; write strobes compare the registered dIdx_r
  function isReg;
    input [9:0] a;
    input [7:0] off;
    begin
      isReg = (a[9:2] == off);
    end
  endfunction

  reg [7:0] ctrl_r;
  reg edgeSel_r;
  wire [2:0] flagVec;
  reg [15:0] count_r;
  reg [1:0] presc_r;
  reg [15:0] capture_r;
  reg [15:0] compare_r;
  reg [7:0] cntBuf_r;
  reg cntBufHeld_r;
  reg cmpHold_r;
  reg capBlock_r;
  reg haltCap_r;
  reg [15:0] haltData_r;
  reg dWr_r;
  reg [7:0] dIdx_r;
  wire edgePulse;
  wire addrPhase;
  wire tick;
  wire match;
  wire capEvent;
  wire ovfEvent;
  wire [7:0] rdByte;
  wire sAccRd, sAccWr;
  reg [7:0] rdMux;

  tmr_edge_detect uEdge (
    .clk(clk),
    .srst(srst),
    .clkEn(clkEn),
    .pinIn(captureInputPin),
    .riseSel(edgeSel_r),
    .edgePulse(edgePulse)
  );

  // address phase of a valid transfer
  assign addrPhase = hsel & hready & htrans[1];
  // read happens in address phase so counter buffering sees the exact access
  assign sAccRd = addrPhase & ~hwrite;
  assign sAccWr = dWr_r;

  // access strobes with a side effect; reads act in the address phase
  wire rdCapHi;
  wire rdCapLo;
  wire rdCntHi;
  wire rdCntLo;
  wire rdMirHi;
  wire rdMirLo;
  wire wrCtrl;
  wire wrCmpHi;
  wire wrCmpLo;
  assign rdCapHi = sAccRd & isReg(haddr, `TMR_OFF_CAP_HI);
  assign rdCapLo = sAccRd & isReg(haddr, `TMR_OFF_CAP_LO);
  assign rdCntHi = sAccRd & isReg(haddr, `TMR_OFF_CNT_HI);
  assign rdCntLo = sAccRd & isReg(haddr, `TMR_OFF_CNT_LO);
  assign rdMirHi = sAccRd & isReg(haddr, `TMR_OFF_MIR_HI);
  assign rdMirLo = sAccRd & isReg(haddr, `TMR_OFF_MIR_LO);
  // writes act in the data phase, where hwdata stands
  assign wrCtrl = sAccWr & (dIdx_r == `TMR_OFF_CTRL);
  assign wrCmpHi = sAccWr & (dIdx_r == `TMR_OFF_CMP_HI);
  assign wrCmpLo = sAccWr & (dIdx_r == `TMR_OFF_CMP_LO);

  // prescaler gives one tick in four cycles, frozen in halt
  assign tick = (presc_r == `TMR_PRESCALE) & ~haltMode;
  assign ovfEvent = tick & (count_r == 16'hffff);
  assign match = (compare_r == count_r) & ~cmpHold_r & ~haltMode;
  assign capEvent = edgePulse & ~haltMode;

  // data phase tracking for writes and write-side data
  always @(posedge clk) begin
    if (srst) begin
      dWr_r <= 1'b0;
      dIdx_r <= 8'h00;
    end else if (clkEn) begin
      dWr_r <= addrPhase & hwrite;
      dIdx_r <= haddr[9:2];
    end
  end

  // read data mux; unused bits are zero
  always @* begin
    rdMux = 8'h00;
    case (haddr[9:2])
      `TMR_OFF_CTRL: rdMux = {ctrl_r[7:5], 3'h0, edgeSel_r, ctrl_r[0]};
      `TMR_OFF_FLAGS: rdMux = {flagVec, 5'h00};
      `TMR_OFF_CAP_HI: rdMux = capture_r[15:8];
      `TMR_OFF_CAP_LO: rdMux = capture_r[7:0];
      `TMR_OFF_CMP_HI: rdMux = compare_r[15:8];
      `TMR_OFF_CMP_LO: rdMux = compare_r[7:0];
      `TMR_OFF_CNT_HI: rdMux = count_r[15:8];
      `TMR_OFF_MIR_HI: rdMux = count_r[15:8];
      `TMR_OFF_CNT_LO: rdMux = cntBufHeld_r ? cntBuf_r : count_r[7:0];
      `TMR_OFF_MIR_LO: rdMux = cntBufHeld_r ? cntBuf_r : count_r[7:0];
      default: rdMux = 8'h00;
    endcase
  end
  assign rdByte = rdMux;

  // bus answer: data registered at the address edge, zero wait, always okay
  always @(posedge clk) begin
    if (srst) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clkEn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (sAccRd) begin
        hrdata <= {24'h000000, rdByte};
      end
    end
  end

  // control register; edge select kept out of reset on purpose
  always @(posedge clk) begin
    if (srst) begin
      ctrl_r <= 8'h00;
    end else if (clkEn && wrCtrl) begin
      ctrl_r <= {hwdata[7:5], 4'h0, hwdata[`TMR_CTL_LVL]};
    end
  end
  always @(posedge clk) begin
    if (clkEn && wrCtrl) begin
      edgeSel_r <= hwdata[`TMR_CTL_EDGE];
    end
  end

  // prescaler and counter; reset forces preset even out of halt
  always @(posedge clk) begin
    if (srst) begin
      presc_r <= 2'h0;
      count_r <= `TMR_CNT_PRESET;
    end else if (clkEn && !haltMode) begin
      presc_r <= presc_r + 2'h1;
      if (tick) begin
        count_r <= count_r + 16'h0001;
      end
    end
  end

  // counter low byte buffer for coherent 16-bit reads
  always @(posedge clk) begin
    if (srst) begin
      cntBuf_r <= 8'h00;
      cntBufHeld_r <= 1'b0;
    end else if (clkEn && sAccRd) begin
      if (rdCntHi || rdMirHi) begin
        if (!cntBufHeld_r) begin
          cntBuf_r <= count_r[7:0];
        end
        cntBufHeld_r <= 1'b1;
      end else if (rdCntLo || rdMirLo) begin
        cntBufHeld_r <= 1'b0;
      end
    end
  end

  // compare register with high-byte hold
  always @(posedge clk) begin
    if (srst) begin
      cmpHold_r <= 1'b0;
    end else if (clkEn && sAccWr) begin
      if (wrCmpHi) begin
        compare_r[15:8] <= hwdata[7:0];
        cmpHold_r <= 1'b1;
      end else if (wrCmpLo) begin
        compare_r[7:0] <= hwdata[7:0];
        cmpHold_r <= 1'b0;
      end
    end
  end

  // compare output level, loaded on every match
  always @(posedge clk) begin
    if (srst) begin
      compareOutputPin <= 1'b0;
    end else if (clkEn && match) begin
      compareOutputPin <= ctrl_r[`TMR_CTL_LVL];
    end
  end

  // capture register, with read block and halt arming
  always @(posedge clk) begin
    if (srst) begin
      capBlock_r <= 1'b0;
      haltCap_r <= 1'b0;
      haltData_r <= 16'h0000;
    end else if (clkEn) begin
      if (rdCapHi) begin
        capBlock_r <= 1'b1;
      end else if (rdCapLo) begin
        capBlock_r <= 1'b0;
      end
      if (haltMode && edgePulse && !haltCap_r) begin
        haltCap_r <= 1'b1;
        haltData_r <= count_r;
      end else if (!haltMode && haltCap_r) begin
        haltCap_r <= 1'b0;
      end
      if (capEvent && !capBlock_r) begin
        capture_r <= count_r + 16'h0001; // one more for synchronisation
      end else if (!haltMode && haltCap_r) begin
        capture_r <= haltData_r + 16'h0001;
      end
    end
  end

  // flag vectors: bit 2 capture, bit 1 compare, bit 0 overflow
  wire [2:0] flagSet;
  wire [2:0] flagClr;
  wire [2:0] flagEn;
  wire [2:0] irqSrc;
  wire statusAcc;
  wire haltRelease;
  wire timerIrq_nxt;
  wire wakeReq_nxt;

  // status read or write, either one is the first clearing step
  assign statusAcc = addrPhase & isReg(haddr, `TMR_OFF_FLAGS);
  // a capture armed in halt turns into a flag only once halt drops
  assign haltRelease = ~haltMode & haltCap_r;

  // set conditions
  assign flagSet[2] = capEvent | haltRelease;
  assign flagSet[1] = match;
  assign flagSet[0] = ovfEvent;

  // second steps; the mirror low byte is left out so it never clears overflow
  assign flagClr[2] = rdCapLo;
  assign flagClr[1] = wrCmpLo;
  assign flagClr[0] = rdCntLo;

  // two-step clearing, one copy per flag; a set in the clear cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
      reg flagBit_r;
      reg armBit_r;
      assign flagVec[gi] = flagBit_r;
      always @(posedge clk) begin
        if (srst) begin
          flagBit_r <= 1'b0;
          armBit_r <= 1'b0;
        end else if (clkEn) begin
          if (statusAcc) begin
            armBit_r <= flagBit_r;
          end
          if (flagSet[gi]) begin
            flagBit_r <= 1'b1;
          end else if (armBit_r && flagClr[gi]) begin
            flagBit_r <= 1'b0;
            armBit_r <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // interrupt sources are the flags gated by their enables
  assign flagEn = {ctrl_r[`TMR_CTL_CAP_IE], ctrl_r[`TMR_CTL_CMP_IE],
    ctrl_r[`TMR_CTL_OVF_IE]};
  assign irqSrc = flagVec & flagEn;
  assign timerIrq_nxt = |irqSrc;
  // wait only gates the wake line; the timer itself keeps running
  assign wakeReq_nxt = waitMode & (|irqSrc);

  // registered so both outputs come straight from flops; halt edges raise them only once halt drops
  always @(posedge clk) begin
    if (srst) begin
      timerIrq <= 1'b0;
      wakeReq <= 1'b0;
    end else if (clkEn) begin
      timerIrq <= timerIrq_nxt;
      wakeReq <= wakeReq_nxt;
    end
  end
endmodule // tmr_timer
`default_nettype wire

// ---- logic/tmr_consts.vh ----
// Purpose: constants for the timer control and status block
// Assumes: AHB-Lite word registers, 8-bit data in the low bits
// Notes: capture and compare high bytes sit at 0x14 and 0x16
// Contract
// - control holds capture, compare, overflow interrupt enables; one enables
// - edge select one latches on rising capture edge, zero on falling
// - reset leaves the capture edge select bit unchanged
// - compare level loads into output level on next match, drives pin
// - control bits two to four are unused and read zero
// - status is read-only, three flags, bits four to zero read zero
// - capture flag sets on edge, clears by capture low read after status access
// - compare flag sets on match, clears by compare low write after status access
// - overflow flag sets on wrap, clears by count low read after status access
// - any status access arms the first clearing step
// - mirror count pair returns same count, never clears overflow flag
// - timer runs in wait mode; enabled interrupt wakes the processor
// - halt stops the counter, interrupt exit resumes from held count
// - reset ending halt forces counter to its preset value
// - halt capture edge arms detector only; flag and data appear on wake
// - reset ending halt discards any capture armed in halt
// - counter advances once every four bus clocks
// - count high read latches low byte buffer until low byte read
// - compare high write suspends matching until compare low write
// - capture high read blocks capture transfers until capture low read; a capture armed in halt still transfers on wake
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH
`define TMR_OFF_CAP_HI 8'h14
`define TMR_OFF_CAP_LO 8'h15
`define TMR_OFF_CMP_HI 8'h16
`define TMR_OFF_CMP_LO 8'h17
`define TMR_OFF_CNT_HI 8'h18
`define TMR_OFF_CNT_LO 8'h19
`define TMR_OFF_MIR_HI 8'h1a
`define TMR_OFF_MIR_LO 8'h1b
`define TMR_OFF_CTRL 8'h12
`define TMR_OFF_FLAGS 8'h13
`define TMR_CTL_CAP_IE 7
`define TMR_CTL_CMP_IE 6
`define TMR_CTL_OVF_IE 5
`define TMR_CTL_EDGE 1
`define TMR_CTL_LVL 0
`define TMR_FLG_CAP 7
`define TMR_FLG_CMP 6
`define TMR_FLG_OVF 5
`define TMR_CNT_PRESET 16'hfffc
`define TMR_PRESCALE 2'h3
`endif

// ---- logic/tmr_edge_detect.v ----
// Purpose: capture pin edge detector with polarity select
// Assumes: pin synchronous to clk
// Notes: pulse is one cycle wide
`default_nettype none
module tmr_edge_detect (
  input wire clk,
  input wire srst,
  input wire clkEn,
  input wire pinIn,
  input wire riseSel,
  output wire edgePulse
);
  reg prev_r;
  // previous pin level for edge compare
  always @(posedge clk) begin
    // follow the pin through reset so a high pin gives no false edge after it
    if (srst) begin
      prev_r <= pinIn;
    end else if (clkEn) begin
      prev_r <= pinIn;
    end
  end
  // select rising or falling transition
  assign edgePulse = clkEn & (riseSel ? (pinIn & ~prev_r) : (~pinIn & prev_r));
endmodule // tmr_edge_detect
`default_nettype wire

// ---- tb/tmr_timer_sva.sv ----
// Purpose: port checks for the timer block
// Assumes: read data shows in the cycle after the address
// Notes: flags live inside, so checks use bus reads and pins
`include "tmr_consts.vh"
`default_nettype none
module tmr_timer_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [9:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic waitMode,
  input wire logic haltMode,
  input wire logic compareOutputPin,
  input wire logic timerIrq,
  input wire logic wakeReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // a read taken at this edge
  sequence rdAt(off);
    hsel && hready && clkEn && htrans[1] && !hwrite && haddr == {off, 2'h0};
  endsequence
  ctl_unused_a: assert property (rdAt(`TMR_OFF_CTRL) |=> hrdata[4:2] == 3'h0)
    else $error("control spare bits set");
  flags_low_a: assert property (rdAt(`TMR_OFF_FLAGS) |=> hrdata[31:0] < 32'h100 && hrdata[4:0] == 5'h0)
    else $error("status low bits set");
  unmapped_zero_a: assert property (rdAt(8'h00) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  wake_source_a: assert property ($rose(wakeReq) |-> $past(waitMode))
    else $error("wake outside wait");
  wake_drop_a: assert property (!waitMode && clkEn |=> !wakeReq)
    else $error("wake held after wait");
  halt_pin_a: assert property ($past(haltMode) |-> $stable(compareOutputPin))
    else $error("compare pin moved in halt");
  frozen_a: assert property (!clkEn |=> $stable(timerIrq) && $stable(compareOutputPin))
    else $error("state moved while disabled");
  irq_enable_a: assert property (rdAt(`TMR_OFF_CTRL) ##1 hrdata[7:5] == 3'h0 |-> ##1 !timerIrq)
    else $error("irq with enables off");
endmodule // tmr_timer_sva
bind tmr_timer tmr_timer_sva u_sva (.clk(clk), .srst(srst), .clkEn(clkEn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .waitMode(waitMode), .haltMode(haltMode), .compareOutputPin(compareOutputPin),
  .timerIrq(timerIrq), .wakeReq(wakeReq));
`default_nettype wire

// ---- tb/tmr_pin_model.sv ----
// Purpose: pin side of the timer, drives capture, sees compare
// Assumes: capture line sampled on clk
// Notes: waits after a change so the detector settles
`default_nettype none
module tmr_pin_model (
  input wire logic clk,
  input wire logic compareOutputPin,
  output logic captureInputPin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial captureInputPin = 1'b0;
  // move the line just after an edge
  task automatic drive(input logic lvl);
    @(posedge clk);
    captureInputPin <= lvl;
    repeat (4) @(posedge clk);
  endtask
endmodule // tmr_pin_model
`default_nettype wire

// ---- tb/test_timer_control_status_flags.sv ----
// Purpose: bench for the timer control and status block
// Assumes: zero wait bus, count ticks every four clocks
// Notes: halt is held through reset so the preset can be read
`include "tmr_consts.vh"
`default_nettype none
module test_timer_control_status_flags;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, clkEn = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic waitMode = 1'b0, haltMode = 1'b1, hreadyout, hresp, capPin, cmpPin, irq, wake;
  logic [9:0] haddr = 10'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic [7:0] rd, v0;
  logic [15:0] cnt;
  int fails = 0, samples_checked = 0, cyc = 0;
  tmr_timer u_dut (.clk(clk), .srst(srst), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .captureInputPin(capPin),
    .waitMode(waitMode), .haltMode(haltMode), .compareOutputPin(cmpPin),
    .timerIrq(irq), .wakeReq(wake));
  tmr_pin_model u_pin (.clk(clk), .compareOutputPin(cmpPin), .captureInputPin(capPin));
  always #5 clk = ~clk;
  // cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end
  // one single transfer; read data taken at the data phase edge
  task automatic bus(input logic [7:0] off, input logic wr, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {off, 2'h0};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask
  task automatic rdb(input logic [7:0] off);
    bus(off, 1'b0, 8'h00);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rdb(`TMR_OFF_CNT_HI);
    chk(rd, 8'hff);
    rdb(`TMR_OFF_CNT_LO);
    chk(rd, 8'hfc);
    bus(`TMR_OFF_CTRL, 1'b1, 8'hff);
    rdb(`TMR_OFF_CTRL);
    chk(rd, 8'he3);
    bus(`TMR_OFF_FLAGS, 1'b1, 8'hff);
    rdb(`TMR_OFF_FLAGS);
    chk(rd, 8'h00);
    rdb(8'h00);
    $display("test registers done");
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rdb(`TMR_OFF_CTRL);
    chk(rd & 8'h02, 8'h02);
    bus(`TMR_OFF_CTRL, 1'b1, 8'h20);
    haltMode <= 1'b0;
    rdb(`TMR_OFF_MIR_LO);
    v0 = rd;
    repeat (4) rdb(`TMR_OFF_MIR_LO);
    chk(rd - v0, 8'h03);
    repeat (20) @(posedge clk);
    chk({7'h0, irq}, 8'h01);
    waitMode <= 1'b1;
    rdb(`TMR_OFF_FLAGS);
    chk(rd & 8'h20, 8'h20);
    chk({7'h0, wake}, 8'h01);
    rdb(`TMR_OFF_MIR_LO);
    rdb(`TMR_OFF_FLAGS);
    chk(rd & 8'h20, 8'h20);
    rdb(`TMR_OFF_CNT_LO);
    rdb(`TMR_OFF_FLAGS);
    chk(rd & 8'h20, 8'h00);
    chk({7'h0, irq}, 8'h00);
    waitMode <= 1'b0;
    clkEn <= 1'b0;
    repeat (3) @(posedge clk);
    clkEn <= 1'b1;
    $display("test count and overflow done");
    bus(`TMR_OFF_CTRL, 1'b1, 8'h21);
    rdb(`TMR_OFF_CNT_HI);
    cnt[15:8] = rd;
    rdb(`TMR_OFF_CNT_LO);
    cnt = {cnt[15:8], rd} + 16'h8;
    rdb(`TMR_OFF_FLAGS);
    bus(`TMR_OFF_CMP_HI, 1'b1, cnt[15:8]);
    bus(`TMR_OFF_CMP_LO, 1'b1, cnt[7:0]);
    repeat (40) @(posedge clk);
    chk({7'h0, cmpPin}, 8'h01);
    rdb(`TMR_OFF_FLAGS);
    chk(rd & 8'h40, 8'h40);
    bus(`TMR_OFF_CMP_LO, 1'b1, cnt[7:0]);
    rdb(`TMR_OFF_FLAGS);
    chk(rd & 8'h40, 8'h00);
    $display("test compare done");
    bus(`TMR_OFF_CTRL, 1'b1, 8'h02);
    u_pin.drive(1'b1);
    rdb(`TMR_OFF_FLAGS);
    chk(rd & 8'h80, 8'h80);
    rdb(`TMR_OFF_CTRL);
    chk(rd, 8'h02);
    rdb(`TMR_OFF_CAP_LO);
    u_pin.drive(1'b0);
    rdb(`TMR_OFF_FLAGS);
    chk(rd & 8'h80, 8'h00);
    $display("test capture done");
    rdb(`TMR_OFF_CNT_HI);
    repeat (40) @(posedge clk);
    rdb(`TMR_OFF_CNT_HI);
    rdb(`TMR_OFF_CNT_LO);
    v0 = rd;
    rdb(`TMR_OFF_MIR_LO);
    chk({7'h0, (rd - v0) > 8'h08}, 8'h01);
    rdb(`TMR_OFF_CAP_LO);
    v0 = rd;
    rdb(`TMR_OFF_CAP_HI);
    u_pin.drive(1'b1);
    rdb(`TMR_OFF_CAP_LO);
    chk(rd, v0);
    rdb(`TMR_OFF_FLAGS);
    rdb(`TMR_OFF_CAP_LO);
    haltMode <= 1'b1;
    u_pin.drive(1'b0);
    u_pin.drive(1'b1);
    rdb(`TMR_OFF_FLAGS);
    chk(rd & 8'h80, 8'h00);
    haltMode <= 1'b0;
    rdb(`TMR_OFF_FLAGS);
    chk(rd & 8'h80, 8'h80);
    rdb(`TMR_OFF_CAP_LO);
    haltMode <= 1'b1;
    u_pin.drive(1'b0);
    u_pin.drive(1'b1);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    haltMode <= 1'b0;
    rdb(`TMR_OFF_FLAGS);
    chk(rd & 8'h80, 8'h00);
    $display("test holds and halt done");
    end_sim();
  end
endmodule // test_timer_control_status_flags
`default_nettype wire
